//--- design/io_read_accumulator_pkg.sv
// shared constants and types for the io read and accumulator unit
package io_read_accumulator_pkg;

    // ----------------
    // instruction codes
    // ----------------
    localparam logic [7:0] INSTR_INPUT_READ = 8'h0f;
    localparam logic [7:0] INSTR_ARITH = 8'h13;
    localparam logic [7:0] INSTR_COMPARE = 8'h14;
    localparam logic [7:0] INSTR_BRANCH = 8'h15;

    // ----------------
    // banks, ports, status
    // ----------------
    localparam logic [7:0] BANK_DIGITAL_IN = 8'h00;
    localparam logic [7:0] BANK_ANALOG_IN = 8'h01;
    localparam logic [7:0] BANK_OUT_STATE = 8'h02;
    localparam logic [7:0] PORT_ALL_INPUTS = 8'hff;
    localparam logic [7:0] PORT_ANALOG = 8'h00;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;
    localparam int FRAME_BYTES = 9;
    localparam logic [3:0] LAST_BYTE_IDX = 4'h8;
    localparam int DIV_STEPS = 32;

    // ----------------
    // arithmetic operations
    // ----------------
    typedef enum logic [7:0] {
        OP_ADD = 8'h00,
        OP_SUB = 8'h01,
        OP_MUL = 8'h02,
        OP_DIV = 8'h03,
        OP_MOD = 8'h04,
        OP_AND = 8'h05,
        OP_OR = 8'h06,
        OP_XOR = 8'h07,
        OP_NOT = 8'h08,
        OP_LOAD = 8'h09
    } arith_op_t;

    // branch conditions
    localparam logic [7:0] COND_ZERO = 8'h00;
    localparam logic [7:0] COND_NOT_ZERO = 8'h01;
    localparam logic [7:0] COND_EQUAL = 8'h02;
    localparam logic [7:0] COND_NOT_EQUAL = 8'h03;
    localparam logic [7:0] COND_GREATER = 8'h04;
    localparam logic [7:0] COND_GREATER_EQ = 8'h05;
    localparam logic [7:0] COND_LOWER = 8'h06;
    localparam logic [7:0] COND_LOWER_EQ = 8'h07;

    // ----------------
    // frame carriers
    // ----------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] instr;
        logic [7:0] kind;
        logic [7:0] bank;
        logic [31:0] value;
    } cmd_frame_t;

    typedef struct packed {
        logic [7:0] host_addr;
        logic [7:0] target_addr;
        logic [7:0] status;
        logic [7:0] instr;
        logic [31:0] value;
    } reply_frame_t;

    // compare flags: zero, equal, greater, lower
    typedef struct packed {
        logic zero;
        logic equal;
        logic greater;
        logic lower;
    } cmp_flags_t;

    // bank 0 digital input vector positions
    localparam int DIN_WIDTH = 7;
    localparam int DOUT_WIDTH = 8;

    function automatic logic [7:0] byte_sum8(input logic [63:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s = s + b[i*8 +: 8];
        end
        return s;
    endfunction

endpackage

//--- design/io_read_accumulator_unit.sv
// command executor for input read, accumulator arithmetic and compare
`timescale 1ns/100ps
// Behaviour
// - input read selects port by type, bank
// - digital reads 0/1, analog 16-bit unsigned
// - program mode copies read value into accumulator
// - direct mode replies status ok for a valid port, accumulator kept except port 255 read loads its low byte
// - bank 0 maps analog, down, up lines
// - port 255 packs all inputs low byte
// - analog line readable digital and analog
// - bank 2 returns last set outputs
// - type byte selects ten accumulator operations
// - arithmetic result replaces accumulator
// - direct arithmetic replies ok unless op invalid or divisor zero, echoes operand
// - compare sets flags, accumulator untouched
// - branch test uses flags, eight conditions
module io_read_accumulator_unit
    import io_read_accumulator_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_prog_valid,
    input wire cmd_frame_t i_prog_cmd,
    input wire logic [7:0] i_host_addr,
    input wire logic [7:0] i_module_addr,
    input wire logic i_analog_line_zero_level,
    input wire logic [2:0] i_down_line,
    input wire logic [2:0] i_up_line,
    input wire logic [15:0] i_analog_value,
    input wire logic [7:0] i_out_state,
    input wire logic [7:0] i_branch_cond,
    output logic o_prog_ready,
    output logic o_prog_done,
    output logic o_tx_valid,
    output logic [7:0] o_tx_byte,
    output logic [31:0] o_accumulator,
    output cmp_flags_t o_flags,
    output logic o_branch_taken
);

    // ----------------
    // input synchronisers
    // ----------------
    logic [DIN_WIDTH-1:0] din_meta_q;
    logic [DIN_WIDTH-1:0] din_sync_q;
    logic [15:0] ain_meta_q;
    logic [15:0] ain_sync_q;
    wire logic [DIN_WIDTH-1:0] din_raw = {i_up_line, i_down_line, i_analog_line_zero_level};

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            din_meta_q <= '0;
            din_sync_q <= '0;
            ain_meta_q <= 16'h0;
            ain_sync_q <= 16'h0;
        end else begin
            din_meta_q <= din_raw;
            din_sync_q <= din_meta_q;
            ain_meta_q <= i_analog_value;
            ain_sync_q <= ain_meta_q;
        end
    end

    // ----------------
    // command frame assembly
    // ----------------
    logic [7:0] rx_buf_q [FRAME_BYTES];
    logic [3:0] rx_idx_q;
    logic rx_full_q;

    wire logic [63:0] rx_body = {rx_buf_q[0], rx_buf_q[1], rx_buf_q[2], rx_buf_q[3],
                                 rx_buf_q[4], rx_buf_q[5], rx_buf_q[6], rx_buf_q[7]};
    wire cmd_frame_t rx_cmd = cmd_frame_t'(rx_body);
    wire logic rx_csum_ok = (byte_sum8(rx_body) == rx_buf_q[8]);
    wire logic rx_for_us = (rx_cmd.addr == i_module_addr);

    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_DIV_WAIT, ST_REPLY} state_t;
    state_t state_q;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_idx_q <= 4'h0;
            rx_full_q <= 1'b0;
            for (int i = 0; i < FRAME_BYTES; i++) begin
                rx_buf_q[i] <= 8'h00;
            end
        end else begin
            if (rx_full_q && state_q == ST_IDLE) begin
                rx_full_q <= 1'b0;
            end
            if (i_rx_valid && !rx_full_q) begin
                rx_buf_q[rx_idx_q] <= i_rx_byte;
                if (rx_idx_q == LAST_BYTE_IDX) begin
                    rx_idx_q <= 4'h0;
                    rx_full_q <= 1'b1;
                end else begin
                    rx_idx_q <= rx_idx_q + 4'h1;
                end
            end
        end
    end

    // ----------------
    // command selection
    // ----------------
    cmd_frame_t cmd_q;
    logic direct_q;
    logic csum_bad_q;
    logic [31:0] acc_q;
    cmp_flags_t flags_q;
    reply_frame_t reply_q;

    wire logic take_direct = (state_q == ST_IDLE) && rx_full_q && rx_for_us;
    wire logic take_prog = (state_q == ST_IDLE) && !take_direct && i_prog_valid;
    assign o_prog_ready = (state_q == ST_IDLE) && !take_direct;

    // ----------------
    // input read decode
    // ----------------
    wire logic [7:0] din_vec = {1'b0, din_sync_q};
    wire logic din_port_ok = (cmd_q.kind < 8'(DIN_WIDTH));
    wire logic dout_port_ok = (cmd_q.kind < 8'(DOUT_WIDTH));
    wire logic [2:0] port_sel = cmd_q.kind[2:0];
    wire logic bit_din = din_port_ok ? din_vec[port_sel] : 1'b0;
    wire logic bit_dout = dout_port_ok ? i_out_state[port_sel] : 1'b0;

    logic [31:0] read_value;
    logic read_ok;
    always_comb begin
        read_value = 32'h0;
        read_ok = 1'b1;
        if (cmd_q.bank == BANK_DIGITAL_IN && cmd_q.kind == PORT_ALL_INPUTS) begin
            read_value = {24'h0, din_vec};
        end else if (cmd_q.bank == BANK_DIGITAL_IN) begin
            read_value = {31'h0, bit_din};
            read_ok = din_port_ok;
        end else if (cmd_q.bank == BANK_ANALOG_IN) begin
            read_value = {16'h0, ain_sync_q};
            read_ok = (cmd_q.kind == PORT_ANALOG);
        end else if (cmd_q.bank == BANK_OUT_STATE) begin
            read_value = {31'h0, bit_dout};
            read_ok = dout_port_ok;
        end else begin
            read_ok = 1'b0;
        end
    end

    // ----------------
    // arithmetic decode
    // ----------------
    wire logic [31:0] operand = cmd_q.value;
    wire logic [63:0] product = 64'($signed(acc_q) * $signed(operand));
    wire arith_op_t op = arith_op_t'(cmd_q.kind);
    wire logic op_is_div = (op == OP_DIV) || (op == OP_MOD);
    wire logic op_ok = (cmd_q.kind <= OP_LOAD);

    logic [31:0] arith_result;
    always_comb begin
        arith_result = acc_q;
        unique case (op)
            OP_ADD: arith_result = acc_q + operand;
            OP_SUB: arith_result = acc_q - operand;
            OP_MUL: arith_result = product[31:0];
            OP_AND: arith_result = acc_q & operand;
            OP_OR: arith_result = acc_q | operand;
            OP_XOR: arith_result = acc_q ^ operand;
            OP_NOT: arith_result = ~acc_q;
            OP_LOAD: arith_result = operand;
            default: arith_result = acc_q;
        endcase
    end

    // compare flags, signed
    wire cmp_flags_t cmp_next = '{
        zero: (acc_q == 32'h0),
        equal: (acc_q == operand),
        greater: ($signed(acc_q) > $signed(operand)),
        lower: ($signed(acc_q) < $signed(operand))
    };

    // ----------------
    // divider
    // ----------------
    wire logic div_start = (state_q == ST_EXEC) && (cmd_q.instr == INSTR_ARITH)
                           && op_is_div && (operand != 32'h0);
    wire logic div_done;
    wire logic [31:0] div_quo;
    wire logic [31:0] div_rem;

    serial_divider u_div (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_start(div_start),
        .i_dividend(acc_q),
        .i_divisor(operand),
        .o_done(div_done),
        .o_quotient(div_quo),
        .o_remainder(div_rem)
    );

    // ----------------
    // reply byte stream
    // ----------------
    logic [3:0] tx_idx_q;
    wire logic [63:0] reply_body = reply_q;
    wire logic [7:0] reply_csum = byte_sum8(reply_body);
    wire logic [7:0] tx_pick = (tx_idx_q == LAST_BYTE_IDX) ? reply_csum
                               : reply_body[8'(63 - 8 * tx_idx_q) -: 8];

    function automatic reply_frame_t make_reply(input logic [7:0] h, input logic [7:0] t,
                                                input logic [7:0] s, input logic [7:0] ins,
                                                input logic [31:0] v);
        make_reply = '{host_addr: h, target_addr: t, status: s, instr: ins, value: v};
    endfunction

    // ----------------
    // execution sequencer
    // ----------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            direct_q <= 1'b0;
            csum_bad_q <= 1'b0;
            acc_q <= 32'h0;
            flags_q <= '0;
            reply_q <= '0;
            tx_idx_q <= 4'h0;
            o_prog_done <= 1'b0;
            o_tx_valid <= 1'b0;
            o_tx_byte <= 8'h00;
        end else begin
            o_prog_done <= 1'b0;
            o_tx_valid <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (take_direct) begin
                        cmd_q <= rx_cmd;
                        direct_q <= 1'b1;
                        csum_bad_q <= !rx_csum_ok;
                        state_q <= ST_EXEC;
                    end else if (take_prog) begin
                        cmd_q <= i_prog_cmd;
                        direct_q <= 1'b0;
                        csum_bad_q <= 1'b0;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_q <= direct_q ? ST_REPLY : ST_IDLE;
                    o_prog_done <= !direct_q;
                    reply_q <= make_reply(i_host_addr, i_module_addr, STATUS_OK,
                                          cmd_q.instr, 32'h0);
                    if (csum_bad_q) begin
                        reply_q.status <= STATUS_BAD_CSUM;
                    end else if (cmd_q.instr == INSTR_INPUT_READ) begin
                        reply_q.value <= read_value;
                        reply_q.status <= read_ok ? STATUS_OK : STATUS_BAD_VALUE;
                        if (!direct_q && read_ok) begin
                            acc_q <= read_value;
                        end
                        if (direct_q && read_ok && cmd_q.bank == BANK_DIGITAL_IN
                            && cmd_q.kind == PORT_ALL_INPUTS) begin
                            acc_q <= {acc_q[31:8], din_vec};
                        end
                    end else if (cmd_q.instr == INSTR_ARITH) begin
                        reply_q.value <= operand;
                        reply_q.status <= op_ok ? STATUS_OK : STATUS_BAD_VALUE;
                        if (div_start) begin
                            state_q <= ST_DIV_WAIT;
                            o_prog_done <= 1'b0;
                        end else if (op_ok && !op_is_div) begin
                            acc_q <= arith_result;
                        end else if (op_is_div) begin
                            reply_q.status <= STATUS_BAD_VALUE;
                        end
                    end else if (cmd_q.instr == INSTR_COMPARE) begin
                        flags_q <= cmp_next;
                    end else begin
                        reply_q.status <= STATUS_BAD_CMD;
                    end
                end
                ST_DIV_WAIT: begin
                    if (div_done) begin
                        acc_q <= (op == OP_DIV) ? div_quo : div_rem;
                        state_q <= direct_q ? ST_REPLY : ST_IDLE;
                        o_prog_done <= !direct_q;
                    end
                end
                ST_REPLY: begin
                    o_tx_valid <= 1'b1;
                    o_tx_byte <= tx_pick;
                    if (tx_idx_q == LAST_BYTE_IDX) begin
                        tx_idx_q <= 4'h0;
                        state_q <= ST_IDLE;
                    end else begin
                        tx_idx_q <= tx_idx_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // ----------------
    // branch condition evaluation
    // ----------------
    function automatic logic cond_met(input logic [7:0] c, input cmp_flags_t f);
        unique case (c)
            COND_ZERO: cond_met = f.zero;
            COND_NOT_ZERO: cond_met = !f.zero;
            COND_EQUAL: cond_met = f.equal;
            COND_NOT_EQUAL: cond_met = !f.equal;
            COND_GREATER: cond_met = f.greater;
            COND_GREATER_EQ: cond_met = f.greater || f.equal;
            COND_LOWER: cond_met = f.lower;
            COND_LOWER_EQ: cond_met = f.lower || f.equal;
            default: cond_met = 1'b0;
        endcase
    endfunction

    assign o_branch_taken = cond_met(i_branch_cond, flags_q);
    assign o_accumulator = acc_q;
    assign o_flags = flags_q;

endmodule

//--- design/serial_divider.sv
// sequential signed divider returning quotient and remainder
`timescale 1ns/100ps
module serial_divider
    import io_read_accumulator_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire logic [31:0] i_dividend,
    input wire logic [31:0] i_divisor,
    output logic o_done,
    output logic [31:0] o_quotient,
    output logic [31:0] o_remainder
);

    // ----------------
    // magnitudes and signs
    // ----------------
    wire logic neg_n = i_dividend[31];
    wire logic neg_d = i_divisor[31];
    wire logic [31:0] mag_n = neg_n ? (32'h0 - i_dividend) : i_dividend;
    wire logic [31:0] mag_d = neg_d ? (32'h0 - i_divisor) : i_divisor;

    logic [31:0] quo_q;
    logic [32:0] rem_q;
    logic [31:0] div_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic qneg_q;
    logic rneg_q;

    wire logic [32:0] shifted = {rem_q[31:0], quo_q[31]};
    wire logic [32:0] trial = shifted - {1'b0, div_q};
    wire logic fits = !trial[32];
    wire logic [31:0] quo_next = {quo_q[30:0], fits};
    wire logic [32:0] rem_next = fits ? trial : shifted;

    // ----------------
    // restoring division, one bit per cycle
    // ----------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            quo_q <= 32'h0;
            rem_q <= 33'h0;
            div_q <= 32'h0;
            cnt_q <= 6'h0;
            busy_q <= 1'b0;
            qneg_q <= 1'b0;
            rneg_q <= 1'b0;
            o_done <= 1'b0;
            o_quotient <= 32'h0;
            o_remainder <= 32'h0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !busy_q) begin
                quo_q <= mag_n;
                rem_q <= 33'h0;
                div_q <= mag_d;
                cnt_q <= 6'(DIV_STEPS);
                busy_q <= 1'b1;
                qneg_q <= neg_n ^ neg_d;
                rneg_q <= neg_n;
            end else if (busy_q) begin
                quo_q <= quo_next;
                rem_q <= rem_next;
                cnt_q <= cnt_q - 6'h1;
                if (cnt_q == 6'h1) begin
                    busy_q <= 1'b0;
                    o_done <= 1'b1;
                    o_quotient <= qneg_q ? (32'h0 - quo_next) : quo_next;
                    o_remainder <= rneg_q ? (32'h0 - rem_next[31:0]) : rem_next[31:0];
                end
            end
        end
    end

endmodule

//--- verif/host_frame_driver.sv
// host model sending binary command frames
`timescale 1ns/100ps
module host_frame_driver
    import io_read_accumulator_pkg::*;
(
    input logic i_clk_sys,
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_byte = 8'h00;
    end
    // nine bytes, value msb first, modulo 256 sum; no compare frames sent
    task automatic send(input cmd_frame_t cmd);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            @(negedge i_clk_sys);
            o_rx_valid = 1'b1;
            o_rx_byte = cmd[i*8 +: 8];
            sum = sum + o_rx_byte;
        end
        @(negedge i_clk_sys);
        o_rx_byte = sum;
        @(negedge i_clk_sys);
        o_rx_valid = 1'b0;
        o_rx_byte = ~o_rx_byte;
    endtask
endmodule

//--- verif/io_read_accumulator_unit_assertions.sv
// port assertions for the io read and accumulator unit
`timescale 1ns/100ps
module io_read_accumulator_unit_checker
    import io_read_accumulator_pkg::*;
(
    input logic i_clk_sys,
    input logic i_resetn,
    input logic i_prog_valid,
    input cmd_frame_t i_prog_cmd,
    input logic [7:0] i_host_addr,
    input logic [7:0] i_module_addr,
    input logic [7:0] i_branch_cond,
    input logic o_prog_ready,
    input logic o_prog_done,
    input logic o_tx_valid,
    input logic [7:0] o_tx_byte,
    input logic [31:0] o_accumulator,
    input cmp_flags_t o_flags,
    input logic o_branch_taken
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    wire cmp_w = i_prog_cmd.instr == INSTR_COMPARE;
    wire arith_w = i_prog_cmd.instr == INSTR_ARITH;
    a_reply_nine_bytes: assert property ($rose(o_tx_valid) |=> o_tx_valid [*8] ##1 !o_tx_valid)
        else $error("reply burst is not nine bytes");
    a_reply_header: assert property ($rose(o_tx_valid) |-> o_tx_byte == i_host_addr ##1 o_tx_byte == i_module_addr)
        else $error("reply header bytes wrong");
    a_compare_done: assert property (i_prog_valid && o_prog_ready && cmp_w |-> ##[1:3] o_prog_done)
        else $error("program compare not finished");
    a_compare_keeps_acc: assert property (o_prog_done && cmp_w |-> o_accumulator == $past(o_accumulator))
        else $error("compare changed accumulator");
    a_compare_equal_flag: assert property (o_prog_done && cmp_w |-> o_flags.equal == (o_accumulator == i_prog_cmd.value))
        else $error("equal flag wrong");
    a_compare_greater: assert property (o_prog_done && cmp_w |-> o_flags.greater == ($signed(o_accumulator) > $signed(i_prog_cmd.value)))
        else $error("greater flag wrong");
    a_branch_equal: assert property (i_branch_cond == COND_EQUAL |-> o_branch_taken == o_flags.equal)
        else $error("equal branch wrong");
    a_branch_lower_eq: assert property (i_branch_cond == COND_LOWER_EQ |-> o_branch_taken == (o_flags.lower || o_flags.equal))
        else $error("lower or equal branch wrong");
    a_load_result: assert property (o_prog_done && arith_w && i_prog_cmd.kind == OP_LOAD |-> o_accumulator == i_prog_cmd.value)
        else $error("load result wrong");
    a_add_result: assert property (o_prog_done && arith_w && i_prog_cmd.kind == OP_ADD |-> o_accumulator == $past(o_accumulator) + i_prog_cmd.value)
        else $error("add result wrong");
endmodule
bind io_read_accumulator_unit io_read_accumulator_unit_checker io_read_accumulator_unit_checker_inst (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_prog_valid(i_prog_valid),
    .i_prog_cmd(i_prog_cmd), .i_host_addr(i_host_addr), .i_module_addr(i_module_addr),
    .i_branch_cond(i_branch_cond), .o_prog_ready(o_prog_ready), .o_prog_done(o_prog_done),
    .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .o_accumulator(o_accumulator),
    .o_flags(o_flags), .o_branch_taken(o_branch_taken)
);

//--- verif/test_io_read_accumulator_unit.sv
// testbench for the io read and accumulator unit
`timescale 1ns/100ps
module test_io_read_accumulator_unit;
    import io_read_accumulator_pkg::*;
    logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_prog_valid = 1'b0, i_rx_valid;
    logic i_analog_line_zero_level = 1'b0, o_prog_ready, o_prog_done, o_tx_valid, o_branch_taken;
    logic [2:0] i_down_line = '0, i_up_line = '0;
    logic [7:0] i_rx_byte, i_out_state = '0, i_branch_cond = '0, o_tx_byte, vec;
    logic [15:0] i_analog_value = '0;
    logic [31:0] o_accumulator, exp_acc = '0, v;
    logic [71:0] rx_sr = '0, reply_q[$];
    logic [31:0] acc_q[$];
    cmd_frame_t i_prog_cmd = '0;
    cmp_flags_t o_flags;
    logic [7:0] taken_tbl[3] = '{8'h3a, 8'ha6, 8'hca};
    int miscompares = 0, checks = 0, replies = 0, nrx = 0;
    io_read_accumulator_unit io_read_accumulator_unit_inst (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte),
        .i_prog_valid(i_prog_valid), .i_prog_cmd(i_prog_cmd), .i_host_addr(8'h02),
        .i_module_addr(8'h01), .i_analog_line_zero_level(i_analog_line_zero_level),
        .i_down_line(i_down_line), .i_up_line(i_up_line), .i_analog_value(i_analog_value),
        .i_out_state(i_out_state), .i_branch_cond(i_branch_cond), .o_prog_ready(o_prog_ready),
        .o_prog_done(o_prog_done), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
        .o_accumulator(o_accumulator), .o_flags(o_flags), .o_branch_taken(o_branch_taken));
    host_frame_driver host_frame_driver_inst (.i_clk_sys(i_clk_sys), .o_rx_valid(i_rx_valid),
        .o_rx_byte(i_rx_byte));
    initial forever #10 i_clk_sys = ~i_clk_sys;
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic compare_reply(input logic [71:0] exp, input logic [71:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] reply frame expected %h seen %h", exp, got);
        end
    endtask
    task automatic compare_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [71:0] reply_of(input logic [7:0] ins, input logic [31:0] rv);
        logic [63:0] b;
        logic [7:0] s;
        b = {8'h02, 8'h01, STATUS_OK, ins, rv};
        s = 8'h00;
        for (int i = 0; i < 8; i++) s = s + b[i*8 +: 8];
        return {b, s};
    endfunction
    function automatic logic [31:0] accumulator_arith_instr(input int op, input logic [31:0] a, input logic [31:0] b);
        case (op)
            0: return a + b;
            1: return a - b;
            2: return a * b;
            3: return $signed(a) / $signed(b);
            4: return $signed(a) % $signed(b);
            5: return a & b;
            6: return a | b;
            7: return a ^ b;
            8: return ~a;
            default: return b;
        endcase
    endfunction
    always @(posedge i_clk_sys) begin
        if (o_tx_valid === 1'b1) begin
            rx_sr = {rx_sr[63:0], o_tx_byte};
            nrx++;
            if (nrx == FRAME_BYTES) begin
                nrx = 0;
                replies++;
                compare_reply(reply_q.pop_front(), rx_sr);
            end
        end
        if (o_prog_done === 1'b1) compare_val("program acc", acc_q.pop_front(), o_accumulator);
    end
    task automatic direct(input logic [7:0] ins, kd, bk, input logic [31:0] val, rv);
        int n;
        n = replies;
        reply_q.push_back(reply_of(ins, rv));
        host_frame_driver_inst.send({8'h01, ins, kd, bk, val});
        for (int t = 0; t < 200 && replies == n; t++) @(negedge i_clk_sys);
        if (replies == n) begin
            miscompares++;
            complete_run();
        end
    endtask
    task automatic prog(input logic [7:0] ins, kd, input logic [31:0] val);
        acc_q.push_back(exp_acc);
        i_prog_cmd = {8'h00, ins, kd, BANK_ANALOG_IN, val};
        i_prog_valid = 1'b1;
        for (int t = 0; t < 100 && o_prog_ready !== 1'b1; t++) @(negedge i_clk_sys);
        @(negedge i_clk_sys);
        i_prog_valid = 1'b0;
        for (int t = 0; t < 100 && acc_q.size() != 0; t++) @(negedge i_clk_sys);
        if (acc_q.size() != 0) begin
            miscompares++;
            complete_run();
        end
    endtask
    initial begin
        void'($urandom(32'h178b));
        repeat (8) @(negedge i_clk_sys);
        i_resetn = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        compare_val("reset acc", 32'h0, o_accumulator);
        for (int r = 0; r < 4; r++) begin
            {i_analog_line_zero_level, i_down_line, i_up_line} = 7'($urandom());
            i_out_state = 8'($urandom());
            i_analog_value = 16'($urandom());
            repeat (3) @(negedge i_clk_sys);
            vec = {1'b0, i_up_line, i_down_line, i_analog_line_zero_level};
            for (int p = 0; p < 7; p++) direct(INSTR_INPUT_READ, 8'(p), BANK_DIGITAL_IN, $urandom(), {31'h0, vec[p]});
            for (int p = 0; p < 8; p++) direct(INSTR_INPUT_READ, 8'(p), BANK_OUT_STATE, 32'h0, {31'h0, i_out_state[p]});
            direct(INSTR_INPUT_READ, PORT_ANALOG, BANK_ANALOG_IN, $urandom(), {16'h0, i_analog_value});
            compare_val("direct read acc", exp_acc, o_accumulator);
            direct(INSTR_INPUT_READ, PORT_ALL_INPUTS, BANK_DIGITAL_IN, 32'h0, {24'h0, vec});
            exp_acc = {exp_acc[31:8], vec};
            compare_val("input vector", exp_acc, o_accumulator);
            $display("input read round %0d done", r);
        end
        for (int k = 0; k < 11; k++) begin
            v = 32'($urandom_range(1, 999));
            if ($urandom() % 2) v = -v;
            exp_acc = accumulator_arith_instr((k + 9) % 10, exp_acc, v);
            direct(INSTR_ARITH, 8'((k + 9) % 10), 8'h00, v, v);
            compare_val("arith acc", exp_acc, o_accumulator);
        end
        $display("arithmetic test done");
        i_analog_value = 16'($urandom()) | 16'h1;
        repeat (3) @(negedge i_clk_sys);
        exp_acc = {16'h0, i_analog_value};
        prog(INSTR_INPUT_READ, PORT_ANALOG, 32'h0);
        for (int c = 0; c < 3; c++) begin
            prog(INSTR_COMPARE, 8'h00, exp_acc + c - 1);
            for (int k = 0; k < 8; k++) begin
                i_branch_cond = 8'(k);
                @(negedge i_clk_sys);
                compare_val("branch", {31'h0, taken_tbl[c][k]}, {31'h0, o_branch_taken});
            end
        end
        v = $urandom();
        exp_acc = v;
        prog(INSTR_ARITH, OP_LOAD, v);
        exp_acc = v + 32'h5;
        prog(INSTR_ARITH, OP_ADD, 32'h5);
        $display("program port test done");
        complete_run();
    end
endmodule
